// ---- common/dstc_pkg.sv ----
// Package for the disk sector transfer controller: register map, fields, codes, carriers.
// Assumes one 100 MHz APB clock domain; memory and drive sides use the carriers below.
package dstc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] REG_MADDR = 8'h00;
	localparam logic [7:0] REG_WCNT  = 8'h04;
	localparam logic [7:0] REG_DSEL  = 8'h08;
	localparam logic [7:0] REG_CYL   = 8'h0C;
	localparam logic [7:0] REG_DADR  = 8'h10;
	localparam logic [7:0] REG_CMD   = 8'h14;
	localparam logic [7:0] REG_ERR   = 8'h18;
	localparam logic [7:0] REG_EPOS  = 8'h1C;
	localparam logic [7:0] REG_EPAT  = 8'h20;
	localparam logic [7:0] REG_ICFG  = 8'h24;

	// Command register fields
	localparam int CMD_IE_BIT   = 6;
	localparam int CMD_RDY_BIT  = 7;
	localparam int CMD_ATTN_BIT = 14;
	localparam int CMD_SERR_BIT = 15;

	// Error register fields
	localparam int ERR_HCK  = 0;
	localparam int ERR_UNC  = 1;
	localparam int ERR_WP   = 2;
	localparam int ERR_NXD  = 3;
	localparam int ERR_WCK  = 4;
	localparam int ERR_OVR  = 5;
	localparam int ERR_CORR = 6;
	localparam int ERR_W    = 7;

	// Reset values and counts
	localparam logic [7:0]  RST_BYTE   = 8'h00;
	localparam logic        RST_READY  = 1'b1;
	localparam logic [5:0]  HDR_LAST   = 6'h2F;
	localparam logic [5:0]  HDR_BITS   = 6'h20;
	localparam logic [5:0]  WORD_LAST  = 6'h0F;
	localparam logic [5:0]  ECC_LAST   = 6'h1F;
	localparam int          BURST_MAX  = 11;
	localparam int          MAX_DRIVES = 8;
	localparam logic [15:0] HCK_POLY   = 16'h1021;
	localparam logic [15:0] HCK_INIT   = 16'hFFFF;
	localparam logic [31:0] ECC_POLY   = 32'h04C11DB7;
	localparam logic [31:0] ECC_INIT   = 32'h00000000;
	localparam logic        PARITY_ODD = 1'b1;
	localparam logic [2:0]  IRQ_PRIO_DEF = 3'h5;
	localparam logic [8:0]  IRQ_VEC_DEF  = 9'h088;  // Octal 210
	localparam logic [21:0] MADDR_STEP = 22'h000002;

	////////////////////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {
		F_NOP   = 3'h0,
		F_READ  = 3'h1,
		F_WRITE = 3'h2,
		F_WCHK  = 3'h3
	} dstc_func_e;

	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_SEEK = 3'b001,
		S_HDR  = 3'b011,
		S_DATA = 3'b010,
		S_ECC  = 3'b110,
		S_DONE = 3'b100
	} dstc_state_e;

	typedef struct packed {
		logic        valid;
		logic        we;
		logic [21:0] addr;
		logic [15:0] wdata;
		logic        wpar;
	} dstc_mem_req_s;

	typedef struct packed {
		logic        ack;
		logic [15:0] rdata;
	} dstc_mem_rsp_s;

	typedef struct packed {
		logic [2:0]  unit;
		logic        sel;
		logic        seek_req;
		logic [15:0] seek_cyl;
		logic        rd_gate;
		logic        wr_gate;
		logic        wr_bit;
		logic        wr_valid;
	} dstc_drv_out_s;

	typedef struct packed {
		logic [7:0]  present;
		logic [7:0]  wprot;
		logic [15:0] cur_cyl;
		logic        seek_done;
		logic        attn;
		logic        rd_bit;
		logic        rd_valid;
		logic        wr_ready;
	} dstc_drv_in_s;

endpackage

// ---- logic/dstc_ctrl.sv ----
// Disk sector transfer controller: APB registers, sector search, DMA word moves, checks.
// Assumes the drive delivers and accepts one bit per qualified cycle and memory acks each request.
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module dstc_ctrl
	import dstc_pkg::*;
(
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [7:0]    paddr,
	input  wire logic [31:0]   pwdata,
	output logic [31:0]        prdata,
	output logic               pready,
	output logic               pslverr,
	output dstc_mem_req_s      mem_o,
	input  wire dstc_mem_rsp_s mem_i,
	output dstc_drv_out_s      drv_o,
	input  wire dstc_drv_in_s  drv_i,
	input  wire logic          irq_cfg_en,
	input  wire logic [2:0]    irq_prio_sel,
	input  wire logic [8:0]    irq_vec_sel,
	output logic               irq,
	output logic [2:0]         irq_prio,
	output logic [8:0]         irq_vec
);

	////////////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic par_bit(input logic [15:0] d);
		par_bit = (^d) ^ PARITY_ODD;
	endfunction

	function automatic logic [15:0] hck_step(input logic [15:0] c, input logic b);
		hck_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? HCK_POLY : 16'h0000);
	endfunction

	function automatic logic [31:0] ecc_step(input logic [31:0] c, input logic b);
		ecc_step = {c[30:0], 1'b0} ^ ((c[31] ^ b) ? ECC_POLY : 32'h00000000);
	endfunction

	// Lowest set bit of the syndrome, and whether all set bits sit in one short burst
	function automatic logic [5:0] burst_info(input logic [31:0] s);
		logic       found;
		logic [4:0] lo;
		logic [4:0] hi;
		found = 1'b0;
		lo = 5'h00;
		hi = 5'h00;
		for (int i = 0; i < 32; i++) begin
			if (s[i]) begin
				if (!found) begin
					lo = 5'(i);
				end
				hi = 5'(i);
				found = 1'b1;
			end
		end
		burst_info = {(32'(hi) - 32'(lo)) < BURST_MAX, lo};
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// State
	dstc_state_e state, next_state;
	logic [21:0] maddr;
	logic [15:0] wcnt;
	logic [2:0]  dsel;
	logic [15:0] cyl;
	logic [15:0] dadr;
	dstc_func_e  func;
	logic        cmd_ie;
	logic        ready;
	logic        attn;
	logic [ERR_W-1:0] err;
	logic [31:0] epos;
	logic [31:0] epat;
	logic [5:0]  bitn;
	logic [15:0] wleft;
	logic [47:0] hdr_sr;
	logic [15:0] hck;
	logic [15:0] word_sr;
	logic        have_word;
	logic [31:0] ecc_acc;
	logic [31:0] ecc_sr;

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode
	wire         acc_wr   = psel & penable & pready & pwrite;
	wire         idle     = (state == S_IDLE);
	wire         wr_cmd   = acc_wr & (paddr == REG_CMD);
	wire         wr_err   = acc_wr & (paddr == REG_ERR);
	wire         wr_parm  = acc_wr & idle;
	wire [2:0]   new_func = pwdata[2:0];
	wire         go       = wr_cmd & idle & (new_func != F_NOP);
	wire         sel_ok   = drv_i.present[dsel];
	wire         go_nxd   = go & !sel_ok;
	wire         go_wp    = go & sel_ok & drv_i.wprot[dsel] & (new_func == F_WRITE);
	wire         go_run   = go & !go_nxd & !go_wp;
	wire         on_cyl   = (drv_i.cur_cyl == cyl);
	wire         is_wr    = (func == F_WRITE);
	wire         serr     = |err;
	wire         mapped   = (paddr[1:0] == 2'b00) && (paddr <= REG_ICFG);
	wire [31:0]  cmd_view = {16'h0000, serr, attn, 6'h00, ready, cmd_ie, 3'h0, func};
	wire [31:0]  rd_mux   = (paddr == REG_MADDR) ? {10'h000, maddr} :
		(paddr == REG_WCNT) ? {16'h0000, wcnt} :
		(paddr == REG_DSEL) ? {29'h00000000, dsel} :
		(paddr == REG_CYL)  ? {16'h0000, cyl} :
		(paddr == REG_DADR) ? {16'h0000, dadr} :
		(paddr == REG_CMD)  ? cmd_view :
		(paddr == REG_ERR)  ? {25'h0000000, err} :
		(paddr == REG_EPOS) ? epos :
		(paddr == REG_EPAT) ? epat :
		(paddr == REG_ICFG) ? {20'h00000, irq_vec, irq_prio} : 32'h00000000;

	////////////////////////////////////////////////////////////////////////////////
	// Datapath events
	wire         bit_in    = drv_i.rd_valid & !is_wr;
	wire         rbit      = drv_i.rd_bit;
	wire         hdr_end   = (state == S_HDR) & drv_i.rd_valid & (bitn == HDR_LAST);
	wire [15:0]  hck_rx    = {hdr_sr[14:0], rbit};
	wire         hck_ok    = (hck_rx == hck);
	// At the last header bit only 47 bits have been shifted in, so the fields sit one place low
	wire         hdr_match = (hdr_sr[46:31] == cyl) && (hdr_sr[30:15] == dadr);
	wire [15:0]  rx_word   = {word_sr[14:0], rbit};
	wire         word_full = (state == S_DATA) & bit_in & (bitn == WORD_LAST);
	wire         tx_bit    = (state == S_DATA) & is_wr & have_word & drv_i.wr_ready;
	wire         tx_last   = tx_bit & (bitn == WORD_LAST);
	wire         ecc_tx    = (state == S_ECC) & is_wr & drv_i.wr_ready;
	wire         ecc_rx    = (state == S_ECC) & bit_in;
	wire         ecc_end   = (ecc_tx | ecc_rx) & (bitn == ECC_LAST);
	wire [31:0]  syndrome  = ecc_acc ^ {ecc_sr[30:0], rbit};
	wire [5:0]   binfo     = burst_info(syndrome);
	wire         mem_done  = mem_o.valid & mem_i.ack;
	wire         fetch     = (state == S_DATA) & is_wr & !have_word & !mem_o.valid;
	wire         data_last = (wleft == 16'h0001);
	wire         finish    = (state == S_DONE) & !mem_o.valid;

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_comb begin
		next_state = state;
		case (state)
			S_IDLE: if (go_run) next_state = on_cyl ? S_HDR : S_SEEK;
			S_SEEK: if (drv_i.seek_done) next_state = S_HDR;
			S_HDR: begin
				if (hdr_end && !hck_ok) begin
					next_state = S_DONE;
				end else if (hdr_end && hdr_match) begin
					next_state = (wleft == 16'h0000) ? S_ECC : S_DATA;
				end
			end
			S_DATA: if ((word_full || tx_last) && data_last) next_state = S_ECC;
			S_ECC:  if (ecc_end) next_state = S_DONE;
			S_DONE: if (finish) next_state = S_IDLE;
			default: next_state = S_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= S_IDLE;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB slave: data prepared in setup, one access cycle, then released
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata  <= rd_mux;
			pready  <= psel & !penable;
			pslverr <= psel & !penable & !mapped;
		end
	end

	// Parameters only change while idle; a busy transfer owns address and count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			maddr  <= 22'h000000;
			wcnt   <= 16'h0000;
			dsel   <= 3'h0;
			cyl    <= 16'h0000;
			dadr   <= 16'h0000;
			func   <= F_NOP;
			cmd_ie <= 1'b0;
		end else begin
			if (mem_done) begin
				maddr <= maddr + MADDR_STEP;
				wcnt  <= wcnt - 16'h0001;
			end else if (wr_parm && paddr == REG_MADDR) begin
				maddr <= pwdata[21:0];
			end else if (wr_parm && paddr == REG_WCNT) begin
				wcnt <= pwdata[15:0];
			end
			if (wr_parm && paddr == REG_DSEL) dsel <= pwdata[2:0];
			if (wr_parm && paddr == REG_CYL) cyl <= pwdata[15:0];
			if (wr_parm && paddr == REG_DADR) dadr <= pwdata[15:0];
			if (wr_cmd) cmd_ie <= pwdata[CMD_IE_BIT];
			if (go) func <= dstc_func_e'(new_func);
		end
	end

	// Status flags: hardware set wins over a software clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready <= RST_READY;
			attn  <= 1'b0;
			err   <= '0;
			epos  <= 32'h00000000;
			epat  <= 32'h00000000;
		end else begin
			if (go) begin
				ready <= 1'b0;
			end else if (finish && !serr) begin
				ready <= 1'b1;
			end
			attn <= drv_i.attn | (attn & !(wr_cmd & pwdata[CMD_ATTN_BIT]));
			err <= (go ? '0 : (wr_err ? (err & ~pwdata[ERR_W-1:0]) : err))
				| (ERR_W'(go_nxd) << ERR_NXD)
				| (ERR_W'(go_wp) << ERR_WP)
				| (ERR_W'(hdr_end & !hck_ok) << ERR_HCK)
				| (ERR_W'(word_full & mem_o.valid) << ERR_OVR)
				| (ERR_W'(mem_done & !mem_o.we & (func == F_WCHK) & (mem_i.rdata != mem_o.wdata)) << ERR_WCK)
				| (ERR_W'(ecc_rx & ecc_end & (syndrome != 32'h0) & binfo[5]) << ERR_CORR)
				| (ERR_W'(ecc_rx & ecc_end & (syndrome != 32'h0) & !binfo[5]) << ERR_UNC);
			if (ecc_rx && ecc_end && syndrome != 32'h0) begin
				epos <= {5'h00, 11'(syndrome >> binfo[4:0]), 11'h000, binfo[4:0]};
				epat <= syndrome;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bit counter, header search and code generators
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bitn    <= 6'h00;
			hdr_sr  <= 48'h000000000000;
			hck     <= HCK_INIT;
			ecc_acc <= ECC_INIT;
			ecc_sr  <= 32'h00000000;
			wleft   <= 16'h0000;
		end else begin
			if (go_run || hdr_end || word_full || tx_last || ecc_end) begin
				bitn <= 6'h00;
			end else if ((state == S_HDR && drv_i.rd_valid) || bit_in || tx_bit || ecc_tx) begin
				bitn <= bitn + 6'h01;
			end
			if (state == S_HDR && drv_i.rd_valid) hdr_sr <= {hdr_sr[46:0], rbit};
			if (go_run || hdr_end) begin
				hck <= HCK_INIT;
			end else if (state == S_HDR && drv_i.rd_valid && bitn < HDR_BITS) begin
				hck <= hck_step(hck, rbit);
			end
			if (go_run || (hdr_end && hdr_match)) begin
				ecc_acc <= ECC_INIT;
			end else if (state == S_DATA && bit_in) begin
				ecc_acc <= ecc_step(ecc_acc, rbit);
			end else if (tx_bit) begin
				ecc_acc <= ecc_step(ecc_acc, word_sr[15]);
			end else if (ecc_tx) begin
				ecc_acc <= {ecc_acc[30:0], 1'b0};
			end
			if (ecc_rx) ecc_sr <= {ecc_sr[30:0], rbit};
			if (go_run) begin
				wleft <= wcnt;
			end else if (word_full || tx_last) begin
				wleft <= wleft - 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Word assembly and memory requests
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			word_sr   <= 16'h0000;
			have_word <= 1'b0;
			mem_o     <= '0;
		end else begin
			if (mem_done && is_wr) begin
				word_sr   <= mem_i.rdata;
				have_word <= 1'b1;
			end else if (tx_bit) begin
				word_sr   <= {word_sr[14:0], 1'b0};
				have_word <= !tx_last;
			end else if (state == S_DATA && bit_in) begin
				word_sr <= rx_word;
			end
			if (word_full) begin
				mem_o.valid <= 1'b1;
				mem_o.we    <= (func == F_READ);
				mem_o.addr  <= maddr;
				mem_o.wdata <= rx_word;
				mem_o.wpar  <= par_bit(rx_word);
			end else if (fetch) begin
				mem_o.valid <= 1'b1;
				mem_o.we    <= 1'b0;
				mem_o.addr  <= maddr;
			end else if (mem_done) begin
				mem_o.valid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Drive side and interrupt outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drv_o    <= '0;
			irq      <= 1'b0;
			irq_prio <= IRQ_PRIO_DEF;
			irq_vec  <= IRQ_VEC_DEF;
		end else begin
			if (go_run) drv_o.unit <= dsel;
			drv_o.sel      <= (next_state != S_IDLE);
			drv_o.seek_req <= go_run & !on_cyl;
			if (go_run) drv_o.seek_cyl <= cyl;
			drv_o.rd_gate  <= (next_state == S_HDR) ||
				(!is_wr && (next_state == S_DATA || next_state == S_ECC));
			drv_o.wr_gate  <= is_wr && (next_state == S_DATA || next_state == S_ECC);
			drv_o.wr_valid <= tx_bit | ecc_tx;
			drv_o.wr_bit   <= tx_bit ? word_sr[15] : ecc_acc[31];
			// Word parity travels with the stored word only as a checked bus property
			irq      <= cmd_ie & (serr | attn | ready);
			irq_prio <= irq_cfg_en ? irq_prio_sel : IRQ_PRIO_DEF;
			irq_vec  <= irq_cfg_en ? irq_vec_sel : IRQ_VEC_DEF;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		!cmd_ie |=> !irq) else $error("interrupt without enable");
	irq_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
		cmd_ie && ready |=> irq) else $error("ready did not request interrupt");
	par_odd_a: assert property (@(posedge pclk) disable iff (!presetn)
		mem_o.valid && mem_o.we |-> (^{mem_o.wdata, mem_o.wpar}) == PARITY_ODD) else $error("bad parity");
	seek_imp_a: assert property (@(posedge pclk) disable iff (!presetn)
		go_run && !on_cyl |=> state == S_SEEK && drv_o.seek_req) else $error("no implied seek");
	no_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
		go_nxd |=> idle && err[ERR_NXD] && !ready) else $error("absent drive accepted");
	wprot_a: assert property (@(posedge pclk) disable iff (!presetn)
		go_wp |=> idle && err[ERR_WP]) else $error("protected drive written");
	hck_err_a: assert property (@(posedge pclk) disable iff (!presetn)
		hdr_end && !hck_ok |=> err[ERR_HCK] ##1 idle) else $error("header check error lost");
	ready_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(ready) |-> $past(state) == S_DONE && !$past(serr)) else $error("ready without success");
	addr_step_a: assert property (@(posedge pclk) disable iff (!presetn)
		mem_done |=> maddr == $past(maddr) + MADDR_STEP) else $error("address not advanced");
	wr_serial_a: assert property (@(posedge pclk) disable iff (!presetn)
		tx_bit |=> drv_o.wr_valid && drv_o.wr_bit == $past(word_sr[15])) else $error("bit not sent");
	burst_a: assert property (@(posedge pclk) disable iff (!presetn)
		ecc_rx && ecc_end && syndrome != 32'h0 |=> err[ERR_CORR] != err[ERR_UNC]) else $error("ecc verdict");

	read_done_c: cover property (@(posedge pclk) disable iff (!presetn) finish && func == F_READ && !serr);
	write_done_c: cover property (@(posedge pclk) disable iff (!presetn) finish && func == F_WRITE && !serr);
	corr_c: cover property (@(posedge pclk) disable iff (!presetn) ecc_end && ecc_rx && binfo[5] && syndrome != 32'h0);
	seek_c: cover property (@(posedge pclk) disable iff (!presetn) state == S_SEEK ##1 state == S_HDR);

endmodule

// ---- tb/dstc_far.sv ----
// Far side model: memory with random ack delay, drive with seek, bit queues.
// Assumes the bench fills rq before a command and reads wq afterwards.
`timescale 1ns/1ps
module dstc_far
	import dstc_pkg::*;
(
	input  wire logic          pclk,
	input  wire dstc_mem_req_s mem_o,
	output dstc_mem_rsp_s      mem_i,
	input  wire dstc_drv_out_s drv_o,
	output dstc_drv_in_s       drv_i,
	input  wire logic [7:0]    present,
	input  wire logic [7:0]    wprot,
	input  wire logic          attn
);
	logic [15:0] mem [64];
	logic        par [64];
	logic        rq [$];
	logic        wq [$];
	logic [15:0] cyl   = 16'h0000;
	logic [15:0] rdata = 16'h0000;
	logic [3:0]  scnt  = 4'h0;
	logic [1:0]  ph    = 2'h0;
	logic        ack   = 1'b0;
	logic        sdone = 1'b0;
	logic        rvld  = 1'b0;
	logic        rbit  = 1'b0;
	integer      sd    = 55;
	assign mem_i = '{ack, rdata};
	// Write ready drops one cycle in four so the writer sees stalls
	assign drv_i = '{present, wprot, cyl, sdone, attn, rbit, rvld, ph != 2'h3};
	always @(posedge pclk) begin
		ph <= ph + 2'h1;
		ack <= 1'b0;
		sdone <= 1'b0;
		rvld <= 1'b0;
		// Idle lines toggle so no stale value can pass for data
		rbit <= ~rbit;
		rdata <= ~rdata;
		if (mem_o.valid && !ack && $random(sd) % 2 != 0) begin
			ack <= 1'b1;
			rdata <= mem[mem_o.addr[6:1]];
			if (mem_o.we) begin
				mem[mem_o.addr[6:1]] <= mem_o.wdata;
				par[mem_o.addr[6:1]] <= mem_o.wpar;
			end
		end
		if (drv_o.rd_gate && ph == 2'h0 && rq.size() > 0) begin
			rvld <= 1'b1;
			rbit <= rq.pop_front();
		end
		if (drv_o.wr_valid)
			wq.push_back(drv_o.wr_bit);
		if (drv_o.seek_req)
			scnt <= 4'h6;
		else if (scnt != 4'h0)
			scnt <= scnt - 4'h1;
		if (scnt == 4'h1) begin
			sdone <= 1'b1;
			cyl <= drv_o.seek_cyl;
		end
	end
endmodule

// ---- tb/test_disk_sector_transfer_controller.sv ----
// Bench: APB host tasks, sector streams built from the check codes, random data.
// Assumes dstc_far stands on the memory and drive ports.
`timescale 1ns/1ps
module test_disk_sector_transfer_controller
	import dstc_pkg::*;
;
	localparam logic [31:0] IE = 32'h1 << CMD_IE_BIT;
	logic          pclk = 1'b0;
	logic          presetn = 1'b0;
	logic          psel = 1'b0;
	logic          penable = 1'b0;
	logic          pwrite = 1'b0;
	logic [7:0]    paddr = 8'h00;
	logic [31:0]   pwdata = 32'h0;
	logic [31:0]   prdata;
	logic          pready;
	logic          pslverr;
	dstc_mem_req_s mem_o;
	dstc_mem_rsp_s mem_i;
	dstc_drv_out_s drv_o;
	dstc_drv_in_s  drv_i;
	logic          irq_cfg_en = 1'b0;
	logic [2:0]    irq_prio_sel = 3'h0;
	logic [8:0]    irq_vec_sel = 9'h000;
	logic          irq;
	logic [2:0]    irq_prio;
	logic [8:0]    irq_vec;
	logic [7:0]    wprot = 8'h02;
	logic          attn = 1'b0;
	logic [31:0]   rdv;
	logic          erv;
	logic [15:0]   wd [8];
	integer        seed = 55;
	int            num_errors = 0;
	int            n_checks = 0;
	always #5 pclk = ~pclk;
	dstc_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_o(mem_o),
		.mem_i(mem_i), .drv_o(drv_o), .drv_i(drv_i), .irq_cfg_en(irq_cfg_en), .irq_prio_sel(irq_prio_sel),
		.irq_vec_sel(irq_vec_sel), .irq(irq), .irq_prio(irq_prio), .irq_vec(irq_vec));
	// Unit 7 has no number plug
	dstc_far far_u (.pclk(pclk), .mem_o(mem_o), .mem_i(mem_i), .drv_o(drv_o), .drv_i(drv_i),
		.present(8'h7F), .wprot(wprot), .attn(attn));
	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("TB: %0d checks, %0d errors", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			num_errors++;
			$display("ERROR %0s expected %0h seen %0h", nm, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 100 && pready !== 1'b1; i++)
			@(posedge pclk);
		if (pready !== 1'b1)
			num_errors++;
		rdv = prdata;
		erv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_is(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, rdv & m, e);
	endtask
	function automatic logic [15:0] crc16(input logic [31:0] h);
		logic [15:0] c;
		c = HCK_INIT;
		for (int i = 31; i >= 0; i--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ h[i]) ? HCK_POLY : 16'h0000);
		return c;
	endfunction
	function automatic logic [31:0] crc32(input int n);
		logic [31:0] c;
		c = ECC_INIT;
		for (int k = 0; k < n * 16; k++)
			c = {c[30:0], 1'b0} ^ ((c[31] ^ wd[k / 16][15 - k % 16]) ? ECC_POLY : 32'h0);
		return c;
	endfunction
	task automatic put(input logic [47:0] v, input int n);
		for (int i = n - 1; i >= 0; i--)
			far_u.rq.push_back(v[i]);
	endtask
	// A neighbour header first, so the search must skip one
	task automatic sector(input int n, input logic [31:0] ex, input logic [15:0] hx);
		far_u.rq.delete();
		put({32'h01230206, crc16(32'h01230206)}, 48);
		put({32'h01230205, crc16(32'h01230205) ^ hx}, 48);
		for (int k = 0; k < n; k++)
			put({32'h0, wd[k]}, 16);
		put({16'h0, crc32(n) ^ ex}, 32);
	endtask
	task automatic go(input logic [2:0] u, input int n, input logic [31:0] cmd);
		far_u.wq.delete();
		apb(1'b1, REG_MADDR, 32'h10);
		apb(1'b1, REG_WCNT, 32'(n));
		apb(1'b1, REG_DSEL, 32'(u));
		apb(1'b1, REG_CYL, 32'h0123);
		apb(1'b1, REG_DADR, 32'h0205);
		apb(1'b1, REG_CMD, cmd);
		repeat (4) @(negedge pclk);
		for (int i = 0; i < 20000 && drv_o.sel !== 1'b0; i++)
			@(negedge pclk);
		if (drv_o.sel !== 1'b0)
			num_errors++;
		repeat (4) @(negedge pclk);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#800000;
		num_errors++;
		close_out();
	end
	initial begin
		logic [31:0] ex;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd_is("icfg", REG_ICFG, 32'hFFF, {20'h0, IRQ_VEC_DEF, IRQ_PRIO_DEF});
		rd_is("ready", REG_CMD, 32'h80, 32'h80);
		rd_is("hole", 8'h28, 32'hFFFFFFFF, 32'h0);
		chk("slverr", 32'(erv), 32'h1);
		irq_cfg_en <= 1'b1;
		irq_prio_sel <= 3'($random(seed));
		irq_vec_sel <= 9'($random(seed));
		repeat (3) @(negedge pclk);
		chk("prio", 32'(irq_prio), 32'(irq_prio_sel));
		chk("vec", 32'(irq_vec), 32'(irq_vec_sel));
		$display("TB: reset and config done");
		for (int k = 0; k < 8; k++)
			wd[k] = 16'($random(seed));
		sector(4, 32'h0, 16'h0);
		go(3'(($random(seed) & 32'hFF) % 7), 4, IE | 32'(F_READ));
		chk("seek", 32'(far_u.cyl), 32'h0123);
		for (int k = 0; k < 4; k++) begin
			chk("word", 32'(far_u.mem[8 + k]), 32'(wd[k]));
			chk("par", 32'(far_u.par[8 + k]), 32'(~^wd[k]));
		end
		rd_is("maddr", REG_MADDR, 32'hFFFFFFFF, 32'h18);
		rd_is("wcnt", REG_WCNT, 32'hFFFFFFFF, 32'h0);
		rd_is("err", REG_ERR, 32'h7F, 32'h0);
		rd_is("ready", REG_CMD, 32'h80, 32'h80);
		chk("irq", 32'(irq), 32'h1);
		$display("TB: read done");
		// The write fetches from the memory model, so it must hold the expected words
		for (int k = 0; k < 8; k++) begin
			wd[k] = 16'($random(seed));
			far_u.mem[8 + k] = wd[k];
		end
		sector(0, 32'h0, 16'h0);
		go(3'h0, 3, 32'(F_WRITE));
		chk("wlen", 32'(far_u.wq.size()), 32'd80);
		for (int k = 0; k < 80 && k < far_u.wq.size(); k++)
			chk("wbit", 32'(far_u.wq[k]), 32'(k < 48 ? wd[k / 16][15 - k % 16] : crc32(3) >> (79 - k)) & 32'h1);
		for (int v = 0; v < 2; v++) begin
			wd[1] = wd[1] ^ 16'(v);
			sector(3, 32'h0, 16'h0);
			go(3'h0, 3, 32'(F_WCHK));
			rd_is("verify", REG_ERR, 32'h7F, 32'(v) << ERR_WCK);
		end
		$display("TB: write and verify done");
		go(3'h1, 3, 32'(F_WRITE));
		rd_is("wprot", REG_ERR, 32'h7F, 32'h1 << ERR_WP);
		rd_is("noready", REG_CMD, 32'h80, 32'h0);
		chk("irqoff", 32'(irq), 32'h0);
		go(3'h7, 3, IE | 32'(F_READ));
		rd_is("nodrive", REG_ERR, 32'h7F, 32'h1 << ERR_NXD);
		sector(2, 32'h0, 16'h0001);
		go(3'h0, 2, IE | 32'(F_READ));
		rd_is("hdr", REG_ERR, 32'h7F, 32'h1 << ERR_HCK);
		rd_is("serr", REG_CMD, 32'h8000, 32'h8000);
		chk("irqerr", 32'(irq), 32'h1);
		$display("TB: refusals done");
		for (int v = 0; v < 2; v++) begin
			ex = v ? 32'h0000FFFF : 32'h00000020;
			sector(2, ex, 16'h0);
			go(3'h0, 2, 32'(F_READ));
			rd_is("ecc", REG_ERR, 32'h7F, v ? 32'h1 << ERR_UNC : 32'h1 << ERR_CORR);
			if (v == 0) begin
				rd_is("epat", REG_EPAT, 32'hFFFFFFFF, ex);
				rd_is("epos", REG_EPOS, 32'h1F, 32'h5);
			end
		end
		apb(1'b1, REG_CMD, IE);
		// Clear the errors first, so only attention can hold the request up
		apb(1'b1, REG_ERR, 32'h7F);
		repeat (2) @(negedge pclk);
		chk("irqidle", 32'(irq), 32'h0);
		@(posedge pclk);
		attn <= 1'b1;
		@(posedge pclk);
		attn <= 1'b0;
		repeat (3) @(negedge pclk);
		rd_is("attn", REG_CMD, 32'h4000, 32'h4000);
		chk("irqattn", 32'(irq), 32'h1);
		$display("TB: ecc and attention done");
		close_out();
	end
endmodule
